// *** inc/twbf_pkg.sv ***
// Purpose: shared constants and types of the two-wire bus framing slave
// Assumes: one system clock, synchronous active-high reset
// Notes: the bus lines are sampled, never driven high
`default_nettype none
package twbf_pkg;
   localparam int ADDR_W = 7;
   localparam int BYTE_W = 8;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [CNT_W-1:0] CNT_BYTE = 4'h8;
   localparam logic [CNT_W-1:0] CNT_PKT = 4'h9;
   localparam logic [ADDR_W-1:0] GCALL_ADDR = 7'h00;
   localparam logic [3:0] RSVD_PREFIX = 4'hF;
   localparam logic DIR_READ = 1'b1;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

   typedef enum logic [2:0] {
      TWBF_IDLE, TWBF_ADDR, TWBF_ADDR_ACK, TWBF_WR_DATA, TWBF_WR_ACK,
      TWBF_RD_DATA, TWBF_RD_ACK, TWBF_IGNORE
   } twbf_state_t;

   // one received byte with its origin
   typedef struct packed {
      logic [BYTE_W-1:0] data;
      logic gcall;
   } twbf_rx_t;

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic sda_s1;
      logic sda_s2;
      logic scl_q;
      logic sda_q;
      twbf_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [BYTE_W-1:0] sh;
      logic is_read;
      logic is_gcall;
      logic mst_ack;
      logic sda_oe;
      logic busy;
      logic start_p;
      logic rstart_p;
      logic stop_p;
      logic rx_valid;
      twbf_rx_t rx;
      logic tx_take;
   } twbf_regs_t;
endpackage : twbf_pkg
`default_nettype wire

// *** src/twbf_slave.sv ***
// Purpose: slave-side framing of the two-wire serial bus: start/stop, busy, address, data, acknowledge
// Assumes: i_mclk at 20 MHz, bus clock far slower (at least 8x), lines sampled through two flip-flops
// Notes: no clock stretching; a slave unable to serve simply leaves the acknowledge high
//
// Notes on behaviour
// - data line only changes while the clock line is low, except start/stop.
// - start and stop are data-line edges while the clock line is high.
// - bus is busy from a start until the next stop.
// - start while busy is a repeated start; bus stays busy.
// - address packet is nine clocks: seven address, direction, acknowledge.
// - direction bit one means read, zero means write.
// - matched slave pulls acknowledge low; if unable to serve it leaves it high.
// - after address not acknowledged, master ends with stop or repeated start.
// - address byte arrives most significant bit first.
// - all-zero address is general call; enabled slaves acknowledge writes and take data.
// - general call with read direction is never acknowledged.
// - addresses 1111xxx are reserved and never answered.
// - data packet is nine clocks: one byte and one acknowledge.
// - master makes clock and start/stop; receiver makes the acknowledge.
// - receiver acknowledges low on ninth clock, leaves high for not-acknowledge.
// - data bytes travel most significant bit first.
// - lines are only pulled low or released; wired-AND level.
// - interface is inactive while its power-down control is set.
`default_nettype none
module twbf_slave
   import twbf_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_serial_bus_power_down,
   input wire logic [ADDR_W-1:0] i_own_addr,
   input wire logic i_gcall_en,
   input wire logic i_scl_i,
   input wire logic i_sda_i,
   output logic o_sda_o,
   output logic o_sda_oe,
   input wire logic i_rx_ready,
   output logic o_rx_valid,
   output twbf_rx_t o_rx,
   input wire logic i_tx_valid,
   input wire logic [BYTE_W-1:0] i_tx_data,
   output logic o_tx_take,
   output logic o_bus_busy,
   output logic o_start,
   output logic o_rstart,
   output logic o_stop,
   output logic o_read_sel
);
   twbf_regs_t r_ff;
   twbf_regs_t nxt_r;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic [ADDR_W-1:0] addr_in;
   logic addr_own;
   logic addr_gc;

   ////////////////////////////////////////////////////////////////////////////
   // line events, taken only from the second synchroniser stage onward
   always_comb begin
      scl_rise = r_ff.scl_s2 && !r_ff.scl_q;
      scl_fall = !r_ff.scl_s2 && r_ff.scl_q;
      start_det = r_ff.scl_s2 && r_ff.scl_q && r_ff.sda_q && !r_ff.sda_s2;
      stop_det = r_ff.scl_s2 && r_ff.scl_q && !r_ff.sda_q && r_ff.sda_s2;
      addr_in = r_ff.sh[BYTE_W-1:1];
      // reserved prefix and the general-call address never match as own, even if strapped so
      addr_own = (addr_in == i_own_addr) && (addr_in[ADDR_W-1 -: 4] != RSVD_PREFIX)
         && (addr_in != GCALL_ADDR);
      addr_gc = i_gcall_en && (addr_in == GCALL_ADDR) && (r_ff.sh[0] != DIR_READ);
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_r = r_ff;
      nxt_r.scl_s1 = i_scl_i;
      nxt_r.scl_s2 = r_ff.scl_s1;
      nxt_r.sda_s1 = i_sda_i;
      nxt_r.sda_s2 = r_ff.sda_s1;
      nxt_r.scl_q = r_ff.scl_s2;
      nxt_r.sda_q = r_ff.sda_s2;
      nxt_r.start_p = 1'b0;
      nxt_r.rstart_p = 1'b0;
      nxt_r.stop_p = 1'b0;
      nxt_r.rx_valid = 1'b0;
      nxt_r.tx_take = 1'b0;
      if (start_det) begin
         nxt_r.start_p = 1'b1;
         nxt_r.rstart_p = r_ff.busy;
         nxt_r.busy = 1'b1;
         nxt_r.st = TWBF_ADDR;
         nxt_r.cnt = CNT_ZERO;
         nxt_r.sda_oe = 1'b0;
      end else if (stop_det) begin
         nxt_r.stop_p = 1'b1;
         nxt_r.busy = 1'b0;
         nxt_r.st = TWBF_IDLE;
         nxt_r.sda_oe = 1'b0;
      end else if (scl_rise) begin
         // sample on the rising clock; bits 0..7 shift in msb first
         if (r_ff.cnt < CNT_BYTE) begin
            nxt_r.sh = {r_ff.sh[BYTE_W-2:0], r_ff.sda_s2};
         end else begin
            nxt_r.mst_ack = !r_ff.sda_s2;
         end
         nxt_r.cnt = r_ff.cnt + CNT_ONE;
      end else if (scl_fall) begin
         // every drive change happens here, while the clock is low
         case (r_ff.st)
            TWBF_ADDR: begin
               if (r_ff.cnt == CNT_BYTE) begin
                  nxt_r.is_read = (r_ff.sh[0] == DIR_READ);
                  nxt_r.is_gcall = addr_gc;
                  if ((addr_own || addr_gc) && ((r_ff.sh[0] == DIR_READ) ? i_tx_valid : i_rx_ready)) begin
                     nxt_r.sda_oe = 1'b1;
                     nxt_r.st = TWBF_ADDR_ACK;
                  end else begin
                     // not ours or cannot serve: wait for stop or repeated start
                     nxt_r.st = TWBF_IGNORE;
                  end
               end
            end
            TWBF_ADDR_ACK, TWBF_RD_ACK: begin
               nxt_r.cnt = CNT_ZERO;
               if (r_ff.is_read && (r_ff.st == TWBF_ADDR_ACK || r_ff.mst_ack)) begin
                  if (i_tx_valid) begin
                     nxt_r.sh = i_tx_data;
                     nxt_r.tx_take = 1'b1;
                     nxt_r.sda_oe = !i_tx_data[BYTE_W-1];
                     nxt_r.st = TWBF_RD_DATA;
                  end else begin
                     // no byte to send: release and let the master see ones
                     nxt_r.sda_oe = 1'b0;
                     nxt_r.st = TWBF_IGNORE;
                  end
               end else if (r_ff.is_read) begin
                  nxt_r.sda_oe = 1'b0;
                  nxt_r.st = TWBF_IGNORE;
               end else begin
                  nxt_r.sda_oe = 1'b0;
                  nxt_r.st = TWBF_WR_DATA;
               end
            end
            TWBF_WR_DATA: begin
               if (r_ff.cnt == CNT_BYTE) begin
                  nxt_r.rx_valid = 1'b1;
                  nxt_r.rx.data = r_ff.sh;
                  nxt_r.rx.gcall = r_ff.is_gcall;
                  nxt_r.sda_oe = i_rx_ready;
                  nxt_r.st = i_rx_ready ? TWBF_WR_ACK : TWBF_IGNORE;
               end
            end
            TWBF_WR_ACK: begin
               nxt_r.cnt = CNT_ZERO;
               nxt_r.sda_oe = 1'b0;
               nxt_r.st = TWBF_WR_DATA;
            end
            TWBF_RD_DATA: begin
               if (r_ff.cnt == CNT_BYTE) begin
                  nxt_r.sda_oe = 1'b0;
                  nxt_r.st = TWBF_RD_ACK;
               end else begin
                  // the rising clock already shifted sh, so its msb is the next bit out
                  nxt_r.sda_oe = !r_ff.sh[BYTE_W-1];
               end
            end
            TWBF_IDLE, TWBF_IGNORE: begin
               nxt_r.sda_oe = 1'b0;
            end
            default: begin
               nxt_r.st = TWBF_IDLE;
               nxt_r.sda_oe = 1'b0;
            end
         endcase
      end
      if (r_ff.st == TWBF_RD_ACK && r_ff.cnt == CNT_PKT && !scl_fall && !start_det && !stop_det) begin
         nxt_r.sda_oe = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power-down acts as a held reset: lines released, no state kept
   always_ff @(posedge i_mclk) begin
      if (i_rst || i_serial_bus_power_down) begin
         r_ff <= '{st: TWBF_IDLE, cnt: CNT_ZERO, sh: BYTE_ZERO, rx: '{data: BYTE_ZERO, gcall: 1'b0},
                   scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, scl_q: 1'b1, sda_q: 1'b1,
                   default: 1'b0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   always_comb begin
      o_sda_o = 1'b0;
      o_sda_oe = r_ff.sda_oe;
      o_rx_valid = r_ff.rx_valid;
      o_rx = r_ff.rx;
      o_tx_take = r_ff.tx_take;
      o_bus_busy = r_ff.busy;
      o_start = r_ff.start_p;
      o_rstart = r_ff.rstart_p;
      o_stop = r_ff.stop_p;
      o_read_sel = r_ff.is_read;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_sda_hold;
      @(posedge i_mclk) disable iff (i_rst)
      ($changed(o_sda_oe) && o_sda_oe) |-> !r_ff.scl_q;
   endproperty
   a_sda_hold: assert property (p_sda_hold) else $error("sda driven low while clock high");

   property p_start_busy;
      @(posedge i_mclk) disable iff (i_rst || i_serial_bus_power_down)
      start_det |=> (o_bus_busy && o_start && r_ff.st == TWBF_ADDR);
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("start did not mark bus busy");

   property p_busy_hold;
      @(posedge i_mclk) disable iff (i_rst || i_serial_bus_power_down)
      (o_bus_busy && !stop_det) |=> o_bus_busy;
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("bus busy dropped without stop");

   property p_rstart;
      @(posedge i_mclk) disable iff (i_rst || i_serial_bus_power_down)
      o_rstart |-> (o_start && $past(o_bus_busy, 1) && o_bus_busy);
   endproperty
   a_rstart: assert property (p_rstart) else $error("repeated start flagged wrongly");

   property p_addr_ack;
      @(posedge i_mclk) disable iff (i_rst || i_serial_bus_power_down)
      (scl_fall && r_ff.st == TWBF_ADDR && r_ff.cnt == CNT_BYTE && addr_own && r_ff.sh[0] != DIR_READ
       && i_rx_ready && !start_det && !stop_det) |=> o_sda_oe ##0 r_ff.st == TWBF_ADDR_ACK;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

   property p_gcall_read;
      @(posedge i_mclk) disable iff (i_rst)
      (r_ff.st == TWBF_ADDR_ACK) |-> !(r_ff.sh[BYTE_W-1:1] == GCALL_ADDR && r_ff.sh[0] == DIR_READ);
   endproperty
   a_gcall_read: assert property (p_gcall_read) else $error("general call read acknowledged");

   property p_reserved;
      @(posedge i_mclk) disable iff (i_rst)
      (r_ff.st == TWBF_ADDR_ACK && !r_ff.is_gcall) |-> (r_ff.sh[BYTE_W-1 -: 4] != RSVD_PREFIX);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved address acknowledged");

   property p_power_down;
      @(posedge i_mclk) disable iff (i_rst)
      i_serial_bus_power_down |=> (!o_sda_oe && !o_bus_busy && !o_rx_valid);
   endproperty
   a_power_down: assert property (p_power_down) else $error("active while powered down");

   property p_rx_byte;
      @(posedge i_mclk) disable iff (i_rst || i_serial_bus_power_down)
      o_rx_valid |-> ($past(r_ff.cnt, 1) == CNT_BYTE && o_rx.data == $past(r_ff.sh, 1));
   endproperty
   a_rx_byte: assert property (p_rx_byte) else $error("byte delivered before eighth bit");

   property p_stop_idle;
      @(posedge i_mclk) disable iff (i_rst || i_serial_bus_power_down)
      stop_det |=> (!o_bus_busy && o_stop && !o_sda_oe && r_ff.st == TWBF_IDLE);
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop did not free the bus");

   property p_wr_ack;
      @(posedge i_mclk) disable iff (i_rst || i_serial_bus_power_down)
      (scl_fall && r_ff.st == TWBF_WR_DATA && r_ff.cnt == CNT_BYTE)
         |=> (o_rx_valid && o_rx.data == $past(r_ff.sh, 1) && o_sda_oe == $past(i_rx_ready, 1));
   endproperty
   a_wr_ack: assert property (p_wr_ack) else $error("data acknowledge wrong");

   property p_tx_take;
      @(posedge i_mclk) disable iff (i_rst || i_serial_bus_power_down)
      o_tx_take |-> (r_ff.st == TWBF_RD_DATA && r_ff.sh == $past(i_tx_data, 1) && o_sda_oe == !r_ff.sh[BYTE_W-1]);
   endproperty
   a_tx_take: assert property (p_tx_take) else $error("read byte not loaded msb first");

   property p_rd_release;
      @(posedge i_mclk) disable iff (i_rst || i_serial_bus_power_down)
      (r_ff.st == TWBF_RD_ACK) |-> !o_sda_oe;
   endproperty
   a_rd_release: assert property (p_rd_release) else $error("transmitter drove the ack clock");

   property p_addr_shift;
      @(posedge i_mclk) disable iff (i_rst || i_serial_bus_power_down)
      (scl_rise && r_ff.cnt < CNT_BYTE) |=> (r_ff.sh[0] == $past(r_ff.sda_s2, 1));
   endproperty
   a_addr_shift: assert property (p_addr_shift) else $error("bit not shifted in at clock rise");

   c_write: cover property (@(posedge i_mclk) o_rx_valid && !o_rx.gcall);
   c_read: cover property (@(posedge i_mclk) o_tx_take);
   c_rstart: cover property (@(posedge i_mclk) o_rstart);
   c_gcall: cover property (@(posedge i_mclk) o_rx_valid && o_rx.gcall);
   c_refuse: cover property (@(posedge i_mclk) r_ff.st == TWBF_IGNORE && $past(r_ff.st) == TWBF_ADDR);
endmodule : twbf_slave
`default_nettype wire

// *** tb/twbf_master_model.sv ***
// Purpose: behavioural bus master facing the slave: start, stop, nine-clock packets
// Assumes: pull-ups on both lines, 400 ns bus clock period, released lines read high
// Notes: the clock stands high between frames; only low pulls are ever driven
`default_nettype none
module twbf_master_model (
   input wire logic i_sda,
   output logic o_scl_pull,
   output logic o_sda_pull
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_scl_pull = 1'b0;
      o_sda_pull = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // data falls while the clock is high; also works as a repeated start from a low clock
   task automatic start();
      o_sda_pull = 1'b0;
      #100 o_scl_pull = 1'b0;
      #200 o_sda_pull = 1'b1;
      #200 o_scl_pull = 1'b1;
   endtask : start
   task automatic stop();
      o_sda_pull = 1'b1;
      #100 o_scl_pull = 1'b0;
      #200 o_sda_pull = 1'b0;
      #200;
   endtask : stop
   // eight bits msb first, then the ninth clock; last = 1 releases the line there
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
      logic [8:0] word;
      logic [8:0] seen;
      word = {d, last};
      for (int i = 8; i >= 0; i--) begin
         #50 o_sda_pull = !word[i]; // change only with the clock low
         #150 o_scl_pull = 1'b0;
         #100 seen[i] = i_sda;
         #100 o_scl_pull = 1'b1; // nine pulses per packet
      end
      q = seen[8:1];
      ack = seen[0];
   endtask : xfer
endmodule : twbf_master_model
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: self-checking bench of the slave framing against a behavioural master
// Assumes: 50 ns system clock, inputs moved 5 ns after the rising edge
// Notes: acknowledge is read as the sampled wired-AND level, 0 = acknowledged
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import twbf_pkg::*;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic pd = 1'b0, gce = 1'b0, rxr = 1'b0, txv = 1'b0;
   logic [ADDR_W-1:0] own = 7'h2C;
   logic [BYTE_W-1:0] txd = 8'h00;
   logic scl_pull, sda_pull, sda_o, sda_oe, rx_valid, tx_take, busy, st, rst_p, sp, rd_sel;
   twbf_rx_t rx;
   wire logic scl = !scl_pull;
   wire logic sda = !(sda_pull | sda_oe);
   int fail_count = 0, checked = 0, n_st = 0, n_rs = 0, n_sp = 0, n_rx = 0, n_tk = 0, cyc = 0;
   logic [7:0] q;
   logic a;
   initial forever #25 i_mclk = !i_mclk;
   twbf_master_model m (.i_sda(sda), .o_scl_pull(scl_pull), .o_sda_pull(sda_pull));
   twbf_slave DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_serial_bus_power_down(pd), .i_own_addr(own),
      .i_gcall_en(gce), .i_scl_i(scl), .i_sda_i(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
      .i_rx_ready(rxr), .o_rx_valid(rx_valid), .o_rx(rx), .i_tx_valid(txv), .i_tx_data(txd),
      .o_tx_take(tx_take), .o_bus_busy(busy), .o_start(st), .o_rstart(rst_p), .o_stop(sp), .o_read_sel(rd_sel));
   always @(posedge i_mclk) begin
      n_st += int'(st === 1'b1);
      n_rs += int'(rst_p === 1'b1);
      n_sp += int'(sp === 1'b1);
      n_rx += int'(rx_valid === 1'b1);
      n_tk += int'(tx_take === 1'b1);
      cyc++;
      if (cyc == 8000) begin
         fail_count++; // stuck run counts as a mismatch
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic set_in(input logic p, g, r, t, input logic [6:0] o, input logic [7:0] d);
      @(posedge i_mclk);
      #5 {pd, gce, rxr, txv, own, txd} = {p, g, r, t, o, d};
   endtask : set_in
   task automatic settle();
      repeat (6) @(posedge i_mclk);
      #5;
   endtask : settle
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////////
   task automatic sc_write();
      int b0, b1, b2;
      {b0, b1, b2} = {n_st, n_sp, n_rx};
      set_in(1'b0, 1'b0, 1'b1, 1'b0, 7'h2C, 8'h00);
      m.start();
      settle();
      check("busy after start", 9'(busy), 9'h001);
      m.xfer(8'h58, 1'b1, q, a);
      check("address ack", 9'(a), 9'h000);
      m.xfer(8'hC1, 1'b1, q, a);
      check("data ack", 9'(a), 9'h000);
      m.stop();
      settle();
      check("rx byte", rx, 9'h182);
      check("direction", 9'(rd_sel), 9'h000);
      check("busy after stop", 9'(busy), 9'h000);
      check("pulses", 9'({3'(n_st - b0), 3'(n_sp - b1), 3'(n_rx - b2)}), 9'h049);
   endtask : sc_write
   task automatic sc_refuse_gcall();
      int b0;
      b0 = n_rs;
      set_in(1'b0, 1'b1, 1'b1, 1'b0, 7'h2C, 8'h00);
      m.start();
      m.xfer(8'h5A, 1'b1, q, a);
      check("other address", 9'(a), 9'h001);
      m.start();
      settle();
      check("repeated start", 9'({busy, 4'(n_rs - b0)}), 9'h011);
      m.xfer(8'h00, 1'b1, q, a);
      check("gcall ack", 9'(a), 9'h000);
      m.xfer(8'h3E, 1'b1, q, a);
      settle();
      check("gcall byte", rx, 9'h07D);
      m.start();
      m.xfer(8'h01, 1'b1, q, a);
      check("gcall read", 9'(a), 9'h001);
      m.stop();
   endtask : sc_refuse_gcall
   task automatic sc_read();
      int b0;
      b0 = n_tk;
      set_in(1'b0, 1'b0, 1'b0, 1'b1, 7'h2C, 8'h6A);
      m.start();
      m.xfer(8'h59, 1'b1, q, a);
      check("read address ack", 9'(a), 9'h000);
      check("direction", 9'(rd_sel), 9'h001);
      m.xfer(8'hFF, 1'b1, q, a);
      check("read byte", 9'(q), 9'h06A);
      check("tx take", 9'(n_tk - b0), 9'h001);
      m.stop();
   endtask : sc_read
   task automatic sc_unable();
      int b0;
      b0 = n_rx;
      set_in(1'b0, 1'b0, 1'b0, 1'b0, 7'h2C, 8'h00);
      m.start();
      m.xfer(8'h58, 1'b1, q, a);
      check("not ready", 9'(a), 9'h001);
      set_in(1'b0, 1'b0, 1'b1, 1'b0, 7'h7A, 8'h00);
      m.start();
      m.xfer(8'hF4, 1'b1, q, a);
      check("reserved", 9'(a), 9'h001);
      set_in(1'b0, 1'b0, 1'b1, 1'b1, 7'h00, 8'h55);
      m.start();
      m.xfer(8'h01, 1'b1, q, a);
      check("own zero read", 9'(a), 9'h001);
      m.stop();
      set_in(1'b1, 1'b0, 1'b1, 1'b0, 7'h2C, 8'h00);
      m.start();
      m.xfer(8'h58, 1'b1, q, a);
      m.xfer(8'h11, 1'b1, q, a);
      m.stop();
      settle();
      check("powered down", 9'({a, busy, 4'(n_rx - b0)}), 9'h020);
      set_in(1'b0, 1'b0, 1'b1, 1'b0, 7'h2C, 8'h00);
   endtask : sc_unable
   initial begin
      repeat (2) @(posedge i_mclk);
      #5 i_rst = 1'b0;
      settle();
      check("idle oe", 9'({sda_oe, busy, sda_o}), 9'h000);
      sc_write();
      sc_refuse_gcall();
      sc_read();
      sc_unable();
      sc_write();
      print_verdict();
   end
endmodule : tb
`default_nettype wire
